/* src/cpcr_pkg.sv */
// Package with the register map, field layout and codes of the codec path control bank
package cpcr_pkg;

	// ********************************
	// Register map
	// ********************************
	localparam int CPCR_NREG = 7;
	localparam logic [7:0] OFF_INPUT_PATH_CONFIG = 8'h0F;
	localparam logic [7:0] OFF_INPUT_MUTE_POWER = 8'h10;
	localparam logic [7:0] OFF_LOW_LATENCY_CONFIG = 8'h11;
	localparam logic [7:0] OFF_OUTPUT_FILTER_CONFIG = 8'h12;
	localparam logic [7:0] OFF_OUTPUT_GATE_POLARITY = 8'h13;
	localparam logic [7:0] OFF_OUTPUT_ATTEN_MUTE = 8'h14;
	localparam logic [7:0] OFF_OUTPUT_POWER_RAMP = 8'h15;
	localparam logic [7:0] REG_OFFSET [CPCR_NREG] = '{OFF_INPUT_PATH_CONFIG, OFF_INPUT_MUTE_POWER,
		OFF_LOW_LATENCY_CONFIG, OFF_OUTPUT_FILTER_CONFIG, OFF_OUTPUT_GATE_POLARITY,
		OFF_OUTPUT_ATTEN_MUTE, OFF_OUTPUT_POWER_RAMP};
	// Writable bits; reserved bits stay zero
	localparam logic [7:0] REG_WMASK [CPCR_NREG] = '{8'h3F, 8'hFF, 8'hEF, 8'hFF, 8'hFF, 8'hFF, 8'hDF};
	localparam logic [7:0] REG_RESET [CPCR_NREG] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam int IDX_IN_CFG = 0;
	localparam int IDX_IN_MP = 1;
	localparam int IDX_LL = 2;
	localparam int IDX_FLT = 3;
	localparam int IDX_GP = 4;
	localparam int IDX_AM = 5;
	localparam int IDX_PR = 6;

	// ********************************
	// Field positions
	// ********************************
	localparam int SUPPLY_BIT = 5;
	localparam int HPF_BIT = 4;
	localparam int LOW4_LSB = 0;
	localparam int HIGH4_LSB = 4;
	localparam int LOW5_LSB = 0;
	localparam int GATE_LSB = 5;
	localparam int REF_POL_BIT = 4;
	localparam int MAIN_DE_BIT = 4;
	localparam int REF_DE_BIT = 3;
	localparam int MVC_BIT = 2;
	localparam int FLT_LSB = 0;
	localparam int REF_ATT_BIT = 7;
	localparam int MAIN_ATT_BIT = 6;
	localparam int LL_MUTE_BIT = 5;
	localparam int VQ_BIT = 7;
	localparam int GAIN_BIT = 6;

	// ********************************
	// Codes
	// ********************************
	localparam logic [1:0] FLT_INTERP = 2'h0;
	localparam logic [1:0] FLT_HOLD = 2'h1;
	localparam logic [1:0] FLT_TRACK = 2'h2;
	localparam logic [2:0] GATE_OFF = 3'h7;
	localparam logic [2:0] GATE_FULL = 3'h6;
	localparam logic [4:0] GATE_BASE_BITS = 5'h0D;
	localparam logic [4:0] GATE_FULL_BITS = 5'h18;

endpackage : cpcr_pkg

/* src/cpcr_path_ctrl.sv */
// Codec converter path control register bank with decoded path controls
//
// Functional notes
// - High-pass bit enables input path filter
// - Input polarity bits negate input channels
// - Input mute bits silence input channels
// - Input power-down bits power off input paths
// - Low-latency gate code sets depth, 111 disables
// - Low-latency polarity bits invert incoming data
// - Main output gate uses same code set
// - Main de-emphasis only at base rates
// - Reference de-emphasis only at base rates
// - Coupling bit makes reference follow master volume
// - Filter field picks interpolation, hold, tracking
// - Reference output gate uses same code set
// - Output polarity bits invert each output
// - Tracking mode ignores reference polarity bit
// - Reference attenuation bit: ramp or immediate
// - Main attenuation bit: ramp or immediate
// - Low-latency mute bit silences that path
// - Output mute bits silence each output
// - Discharge bit ramps common mode before reset
// - Gain bit gives tracking gain two when flipped
// - Output power-down bits power off outputs
// - Flip plus gain doubles reference offset
`timescale 1ns/1ns
module cpcr_path_ctrl
	import cpcr_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ctl_wr_en,
	input wire logic ctl_rd_en,
	input wire logic [7:0] ctl_addr,
	input wire logic [7:0] ctl_wr_data,
	output logic [7:0] ctl_rd_data,
	output logic ctl_rd_valid,
	input wire logic high_rate,
	input wire logic tracking_ref_flip,
	output logic supply_level_select,
	output logic input_highpass_on,
	output logic [3:0] input_polarity_flip,
	output logic [3:0] input_silence,
	output logic [3:0] input_power_off,
	output logic lowlat_gate_on,
	output logic [4:0] lowlat_gate_depth,
	output logic [3:0] lowlat_polarity_flip,
	output logic lowlat_silence,
	output logic main_out_gate_on,
	output logic [4:0] main_out_gate_depth,
	output logic main_out_deemph,
	output logic ref_out_deemph,
	output logic ref_out_master_vol_follow,
	output logic ref_out_hold,
	output logic ref_out_tracking,
	output logic ref_out_gate_on,
	output logic [4:0] ref_out_gate_depth,
	output logic [4:0] out_polarity_flip,
	output logic ref_out_atten_mode,
	output logic main_out_atten_mode,
	output logic [4:0] out_silence,
	output logic [4:0] out_power_off,
	output logic common_mode_discharge,
	output logic tracking_gain_two,
	output logic tracking_offset_double
);

	// ********************************
	// Decoding helpers
	// ********************************
	// Returns {gate on in bit 5, engage depth in lower five bits}
	function automatic logic [5:0] gate_decode(input logic [2:0] code);
		logic [5:0] res;
		res = 6'h00;
		if (code == GATE_FULL) begin
			res = {1'h1, GATE_FULL_BITS};
		end else if (code != GATE_OFF) begin
			res = {1'h1, GATE_BASE_BITS + {2'h0, code}};
		end
		return res;
	endfunction : gate_decode

	// ********************************
	// Register storage
	// ********************************
	logic [7:0] regs_reg [CPCR_NREG];
	logic [CPCR_NREG-1:0] wr_hit;
	logic [CPCR_NREG-1:0] addr_hit;
	logic [7:0] rd_mux;
	logic [7:0] rd_data_reg;
	logic rd_valid_reg;

	genvar gi;
	generate
		for (gi = 0; gi < CPCR_NREG; gi++) begin : g_reg
			assign addr_hit[gi] = (ctl_addr == REG_OFFSET[gi]);
			assign wr_hit[gi] = ctl_wr_en && addr_hit[gi];
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					regs_reg[gi] <= REG_RESET[gi];
				end else if (wr_hit[gi]) begin
					regs_reg[gi] <= ctl_wr_data & REG_WMASK[gi];
				end
			end
		end
	endgenerate

	always_comb begin
		rd_mux = 8'h00;
		for (int i = 0; i < CPCR_NREG; i++) begin
			if (addr_hit[i]) begin
				rd_mux = regs_reg[i];
			end
		end
	end

	// Read data is captured one edge after the read strobe
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_reg <= 8'h00;
			rd_valid_reg <= 1'b0;
		end else begin
			rd_data_reg <= ctl_rd_en ? rd_mux : 8'h00;
			rd_valid_reg <= ctl_rd_en;
		end
	end

	assign ctl_rd_data = rd_data_reg;
	assign ctl_rd_valid = rd_valid_reg;

	// ********************************
	// Input converter path controls
	// ********************************
	assign supply_level_select = regs_reg[IDX_IN_CFG][SUPPLY_BIT];
	assign input_highpass_on = regs_reg[IDX_IN_CFG][HPF_BIT];
	assign input_polarity_flip = regs_reg[IDX_IN_CFG][LOW4_LSB +: 4];
	assign input_silence = regs_reg[IDX_IN_MP][HIGH4_LSB +: 4];
	assign input_power_off = regs_reg[IDX_IN_MP][LOW4_LSB +: 4];

	// ********************************
	// Low-latency path controls
	// ********************************
	wire [5:0] ll_gate = gate_decode(regs_reg[IDX_LL][GATE_LSB +: 3]);
	assign lowlat_gate_on = ll_gate[5];
	assign lowlat_gate_depth = ll_gate[4:0];
	assign lowlat_polarity_flip = regs_reg[IDX_LL][LOW4_LSB +: 4];
	assign lowlat_silence = regs_reg[IDX_AM][LL_MUTE_BIT];

	// ********************************
	// Output path controls
	// ********************************
	wire [5:0] main_gate = gate_decode(regs_reg[IDX_FLT][GATE_LSB +: 3]);
	wire [5:0] ref_gate = gate_decode(regs_reg[IDX_GP][GATE_LSB +: 3]);
	wire [1:0] flt_code = regs_reg[IDX_FLT][FLT_LSB +: 2];
	assign main_out_gate_on = main_gate[5];
	assign main_out_gate_depth = main_gate[4:0];
	assign ref_out_gate_on = ref_gate[5];
	assign ref_out_gate_depth = ref_gate[4:0];
	// De-emphasis is held off at high or double-speed rates
	assign main_out_deemph = regs_reg[IDX_FLT][MAIN_DE_BIT] && !high_rate;
	assign ref_out_deemph = regs_reg[IDX_FLT][REF_DE_BIT] && !high_rate;
	assign ref_out_master_vol_follow = regs_reg[IDX_FLT][MVC_BIT];
	// Reserved filter code falls back to interpolation; tracking ignores the reference polarity bit
	assign ref_out_hold = (flt_code == FLT_HOLD);
	assign ref_out_tracking = (flt_code == FLT_TRACK);
	assign out_polarity_flip = {regs_reg[IDX_GP][REF_POL_BIT] && !ref_out_tracking, regs_reg[IDX_GP][LOW4_LSB +: 4]};
	assign ref_out_atten_mode = regs_reg[IDX_AM][REF_ATT_BIT];
	assign main_out_atten_mode = regs_reg[IDX_AM][MAIN_ATT_BIT];
	assign out_silence = regs_reg[IDX_AM][LOW5_LSB +: 5];
	assign out_power_off = regs_reg[IDX_PR][LOW5_LSB +: 5];
	assign common_mode_discharge = regs_reg[IDX_PR][VQ_BIT];
	assign tracking_gain_two = tracking_ref_flip && regs_reg[IDX_PR][GAIN_BIT];
	assign tracking_offset_double = tracking_ref_flip && regs_reg[IDX_PR][GAIN_BIT];

	// ********************************
	// Assertions
	// ********************************
	property p_hpf;
		@(posedge mclk) disable iff (!rst_n)
		(ctl_wr_en && ctl_addr == OFF_INPUT_PATH_CONFIG) |=> (input_highpass_on == $past(ctl_wr_data[HPF_BIT]));
	endproperty
	a_hpf: assert property (p_hpf) else $error("highpass enable not taken from write");

	property p_in_mute;
		@(posedge mclk) disable iff (!rst_n)
		(ctl_wr_en && ctl_addr == OFF_INPUT_MUTE_POWER) |=>
			(input_silence == $past(ctl_wr_data[7:4]) && input_power_off == $past(ctl_wr_data[3:0]));
	endproperty
	a_in_mute: assert property (p_in_mute) else $error("input mute or power-down wrong");

	property p_ll_gate;
		@(posedge mclk) disable iff (!rst_n)
		lowlat_gate_on |-> (lowlat_gate_depth >= 5'h0D && lowlat_gate_depth <= 5'h12) || lowlat_gate_depth == 5'h18;
	endproperty
	a_ll_gate: assert property (p_ll_gate) else $error("low-latency gate depth out of range");

	property p_ll_gate_off;
		@(posedge mclk) disable iff (!rst_n)
		(ctl_wr_en && ctl_addr == OFF_LOW_LATENCY_CONFIG && ctl_wr_data[7:5] == 3'h7) |=> !lowlat_gate_on;
	endproperty
	a_ll_gate_off: assert property (p_ll_gate_off) else $error("low-latency gate not disabled");

	property p_main_gate;
		@(posedge mclk) disable iff (!rst_n)
		(ctl_wr_en && ctl_addr == OFF_OUTPUT_FILTER_CONFIG && ctl_wr_data[7:5] == 3'h2) |=>
			(main_out_gate_on && main_out_gate_depth == 5'h0F);
	endproperty
	a_main_gate: assert property (p_main_gate) else $error("main gate code 010 not 15 bits");

	property p_deemph;
		@(posedge mclk) disable iff (!rst_n)
		high_rate |-> !main_out_deemph && !ref_out_deemph;
	endproperty
	a_deemph: assert property (p_deemph) else $error("de-emphasis active at high rate");

	property p_track_pol;
		@(posedge mclk) disable iff (!rst_n)
		ref_out_tracking |-> !out_polarity_flip[4] && !ref_out_hold;
	endproperty
	a_track_pol: assert property (p_track_pol) else $error("reference inverted in tracking mode");

	property p_ref_gate;
		@(posedge mclk) disable iff (!rst_n)
		(ctl_wr_en && ctl_addr == OFF_OUTPUT_GATE_POLARITY && ctl_wr_data[7:5] == 3'h6) |=>
			(ref_out_gate_on && ref_out_gate_depth == 5'h18);
	endproperty
	a_ref_gate: assert property (p_ref_gate) else $error("reference gate code 110 not 24 bits");

	property p_mute_out;
		@(posedge mclk) disable iff (!rst_n)
		(ctl_wr_en && ctl_addr == OFF_OUTPUT_ATTEN_MUTE) |=>
			(out_silence == $past(ctl_wr_data[4:0]) && lowlat_silence == $past(ctl_wr_data[5]));
	endproperty
	a_mute_out: assert property (p_mute_out) else $error("output mute bits wrong");

	property p_reserved;
		@(posedge mclk) disable iff (!rst_n)
		(ctl_rd_en && ctl_addr == OFF_OUTPUT_POWER_RAMP) |=> (ctl_rd_valid && ctl_rd_data[5] == 1'b0);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved bit read non-zero");

	property p_gain;
		@(posedge mclk) disable iff (!rst_n)
		!tracking_ref_flip |-> !tracking_gain_two && !tracking_offset_double;
	endproperty
	a_gain: assert property (p_gain) else $error("tracking gain active without flip");

	// ********************************
	// Field storage and bus checks
	// ********************************
	property p_in_cfg;
		@(posedge mclk) disable iff (!rst_n)
		(ctl_wr_en && ctl_addr == OFF_INPUT_PATH_CONFIG) |=>
			(supply_level_select == $past(ctl_wr_data[SUPPLY_BIT]) &&
			input_polarity_flip == $past(ctl_wr_data[3:0]));
	endproperty
	a_in_cfg: assert property (p_in_cfg) else $error("supply select or input polarity wrong");

	property p_ll_pol;
		@(posedge mclk) disable iff (!rst_n)
		(ctl_wr_en && ctl_addr == OFF_LOW_LATENCY_CONFIG) |=> (lowlat_polarity_flip == $past(ctl_wr_data[3:0]));
	endproperty
	a_ll_pol: assert property (p_ll_pol) else $error("low-latency polarity wrong");

	property p_flt_cfg;
		@(posedge mclk) disable iff (!rst_n)
		(ctl_wr_en && ctl_addr == OFF_OUTPUT_FILTER_CONFIG) |=>
			(ref_out_master_vol_follow == $past(ctl_wr_data[MVC_BIT]) &&
			ref_out_hold == ($past(ctl_wr_data[1:0]) == FLT_HOLD) &&
			ref_out_tracking == ($past(ctl_wr_data[1:0]) == FLT_TRACK));
	endproperty
	a_flt_cfg: assert property (p_flt_cfg) else $error("coupling or filter select wrong");

	property p_deemph_on;
		@(posedge mclk) disable iff (!rst_n)
		(ctl_wr_en && ctl_addr == OFF_OUTPUT_FILTER_CONFIG) |=>
			(main_out_deemph == ($past(ctl_wr_data[MAIN_DE_BIT]) && !high_rate) &&
			ref_out_deemph == ($past(ctl_wr_data[REF_DE_BIT]) && !high_rate));
	endproperty
	a_deemph_on: assert property (p_deemph_on) else $error("de-emphasis not taken from write");

	property p_out_pol;
		@(posedge mclk) disable iff (!rst_n)
		(ctl_wr_en && ctl_addr == OFF_OUTPUT_GATE_POLARITY) |=>
			(out_polarity_flip[3:0] == $past(ctl_wr_data[3:0]) &&
			(ref_out_tracking || out_polarity_flip[4] == $past(ctl_wr_data[4])));
	endproperty
	a_out_pol: assert property (p_out_pol) else $error("output polarity wrong");

	property p_atten;
		@(posedge mclk) disable iff (!rst_n)
		(ctl_wr_en && ctl_addr == OFF_OUTPUT_ATTEN_MUTE) |=>
			(ref_out_atten_mode == $past(ctl_wr_data[REF_ATT_BIT]) &&
			main_out_atten_mode == $past(ctl_wr_data[MAIN_ATT_BIT]));
	endproperty
	a_atten: assert property (p_atten) else $error("attenuation mode wrong");

	property p_pwr;
		@(posedge mclk) disable iff (!rst_n)
		(ctl_wr_en && ctl_addr == OFF_OUTPUT_POWER_RAMP) |=>
			(out_power_off == $past(ctl_wr_data[4:0]) &&
			common_mode_discharge == $past(ctl_wr_data[VQ_BIT]));
	endproperty
	a_pwr: assert property (p_pwr) else $error("output power-down or discharge wrong");

	property p_gain_on;
		@(posedge mclk) disable iff (!rst_n)
		(ctl_wr_en && ctl_addr == OFF_OUTPUT_POWER_RAMP) ##1 tracking_ref_flip |->
			(tracking_gain_two == $past(ctl_wr_data[GAIN_BIT]) &&
			tracking_offset_double == tracking_gain_two);
	endproperty
	a_gain_on: assert property (p_gain_on) else $error("tracking gain not taken from write");

	property p_unmapped;
		@(posedge mclk) disable iff (!rst_n)
		(ctl_rd_en && (ctl_addr < OFF_INPUT_PATH_CONFIG || ctl_addr > OFF_OUTPUT_POWER_RAMP)) |=>
			(ctl_rd_valid && ctl_rd_data == 8'h00);
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

	property p_rsv_in_cfg;
		@(posedge mclk) disable iff (!rst_n)
		(ctl_rd_en && ctl_addr == OFF_INPUT_PATH_CONFIG) |=> (ctl_rd_valid && ctl_rd_data[7:6] == 2'h0);
	endproperty
	a_rsv_in_cfg: assert property (p_rsv_in_cfg) else $error("input config reserved bits non-zero");

	property p_rsv_ll;
		@(posedge mclk) disable iff (!rst_n)
		(ctl_rd_en && ctl_addr == OFF_LOW_LATENCY_CONFIG) |=> (ctl_rd_valid && ctl_rd_data[4] == 1'h0);
	endproperty
	a_rsv_ll: assert property (p_rsv_ll) else $error("low-latency reserved bit non-zero");

	property p_main_depth;
		@(posedge mclk) disable iff (!rst_n)
		main_out_gate_on |->
			(main_out_gate_depth >= 5'h0D && main_out_gate_depth <= 5'h12) || main_out_gate_depth == 5'h18;
	endproperty
	a_main_depth: assert property (p_main_depth) else $error("main gate depth out of range");

	property p_ref_depth;
		@(posedge mclk) disable iff (!rst_n)
		ref_out_gate_on |->
			(ref_out_gate_depth >= 5'h0D && ref_out_gate_depth <= 5'h12) || ref_out_gate_depth == 5'h18;
	endproperty
	a_ref_depth: assert property (p_ref_depth) else $error("reference gate depth out of range");

	property p_gate_idle;
		@(posedge mclk) disable iff (!rst_n)
		(lowlat_gate_on || lowlat_gate_depth == 5'h00) && (main_out_gate_on || main_out_gate_depth == 5'h00) &&
			(ref_out_gate_on || ref_out_gate_depth == 5'h00);
	endproperty
	a_gate_idle: assert property (p_gate_idle) else $error("disabled gate reports a depth");

endmodule : cpcr_path_ctrl

/* testbench/cpcr_path_ctrl_tb.sv */
// Self-checking testbench for the codec path control register bank
`timescale 1ns/1ns
module cpcr_path_ctrl_tb;
	import cpcr_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic ctl_wr_en = 1'b0, ctl_rd_en = 1'b0, high_rate = 1'b0, tracking_ref_flip = 1'b1;
	logic [7:0] ctl_addr = 8'h00, ctl_wr_data = 8'h00, ctl_rd_data;
	logic ctl_rd_valid, supply_level_select, input_highpass_on, lowlat_gate_on, lowlat_silence, main_out_gate_on;
	logic main_out_deemph, ref_out_deemph, ref_out_master_vol_follow, ref_out_hold, ref_out_tracking, ref_out_gate_on;
	logic ref_out_atten_mode, main_out_atten_mode, common_mode_discharge, tracking_gain_two, tracking_offset_double;
	logic [3:0] input_polarity_flip, input_silence, input_power_off, lowlat_polarity_flip;
	logic [4:0] lowlat_gate_depth, main_out_gate_depth, ref_out_gate_depth, out_polarity_flip, out_silence, out_power_off;
	int n_fail = 0;
	int n_compared = 0;
	logic [7:0] t_addr [8] = '{8'h0F, 8'h0F, 8'h10, 8'h10, 8'h14, 8'h14, 8'h15, 8'h15};
	logic [7:0] t_data [8] = '{8'hE5, 8'h1A, 8'hA5, 8'h5A, 8'hB5, 8'h4A, 8'hF5, 8'h2A};
	logic [7:0] t_exp [8] = '{8'h25, 8'h1A, 8'hA5, 8'h5A, 8'hB5, 8'h4A, 8'hD5, 8'h0A};
	logic [4:0] d;

	always #2 mclk = ~mclk;

	cpcr_path_ctrl dut_u (.mclk(mclk), .rst_n(rst_n), .ctl_wr_en(ctl_wr_en), .ctl_rd_en(ctl_rd_en),
		.ctl_addr(ctl_addr), .ctl_wr_data(ctl_wr_data), .ctl_rd_data(ctl_rd_data), .ctl_rd_valid(ctl_rd_valid),
		.high_rate(high_rate), .tracking_ref_flip(tracking_ref_flip), .supply_level_select(supply_level_select),
		.input_highpass_on(input_highpass_on), .input_polarity_flip(input_polarity_flip),
		.input_silence(input_silence), .input_power_off(input_power_off), .lowlat_gate_on(lowlat_gate_on),
		.lowlat_gate_depth(lowlat_gate_depth), .lowlat_polarity_flip(lowlat_polarity_flip),
		.lowlat_silence(lowlat_silence), .main_out_gate_on(main_out_gate_on),
		.main_out_gate_depth(main_out_gate_depth), .main_out_deemph(main_out_deemph),
		.ref_out_deemph(ref_out_deemph), .ref_out_master_vol_follow(ref_out_master_vol_follow),
		.ref_out_hold(ref_out_hold), .ref_out_tracking(ref_out_tracking), .ref_out_gate_on(ref_out_gate_on),
		.ref_out_gate_depth(ref_out_gate_depth), .out_polarity_flip(out_polarity_flip),
		.ref_out_atten_mode(ref_out_atten_mode), .main_out_atten_mode(main_out_atten_mode),
		.out_silence(out_silence), .out_power_off(out_power_off), .common_mode_discharge(common_mode_discharge),
		.tracking_gain_two(tracking_gain_two), .tracking_offset_double(tracking_offset_double));

	// ********************************
	// Access and compare tasks
	// ********************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		ctl_wr_en <= 1'b1;
		ctl_addr <= a;
		ctl_wr_data <= v;
		@(posedge mclk);
		ctl_wr_en <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge mclk);
		ctl_rd_en <= 1'b1;
		ctl_addr <= a;
		@(posedge mclk);
		ctl_rd_en <= 1'b0;
		#1;
		chk({7'h00, ctl_rd_valid}, 8'h01);
		chk(ctl_rd_data, exp);
	endtask : rd

	// Control outputs regrouped into the layout of the register they decode
	function automatic logic [7:0] outs(input logic [7:0] a);
		case (a)
			8'h0F: outs = {2'b00, supply_level_select, input_highpass_on, input_polarity_flip};
			8'h10: outs = {input_silence, input_power_off};
			8'h14: outs = {ref_out_atten_mode, main_out_atten_mode, lowlat_silence, out_silence};
			default: outs = {common_mode_discharge, tracking_gain_two, 1'b0, out_power_off};
		endcase
	endfunction : outs

	task automatic report_and_stop;
		$display("compared %0d mismatched %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop

	// ********************************
	// Scenarios
	// ********************************
	initial begin
		#100000;
		n_fail++;
		report_and_stop;
	end

	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		for (int i = 0; i < 7; i++) rd(8'h0F + i[7:0], 8'h00);
		chk({2'b00, lowlat_gate_on, lowlat_gate_depth}, 8'h2D);
		for (int i = 0; i < 8; i++) begin
			wr(t_addr[i], t_data[i]);
			chk(outs(t_addr[i]), t_exp[i]);
			rd(t_addr[i], t_exp[i]);
		end
		for (int c = 0; c < 8; c++) begin
			d = (c == 7) ? 5'h00 : (c == 6) ? 5'h18 : 5'h0D + 5'(c);
			wr(8'h11, {c[2:0], 5'h1C});
			wr(8'h12, {c[2:0], 5'h00});
			wr(8'h13, {c[2:0], 5'h00});
			chk({2'b00, lowlat_gate_on, lowlat_gate_depth}, {2'b00, c != 7, d});
			chk({2'b00, main_out_gate_on, main_out_gate_depth}, {2'b00, c != 7, d});
			chk({2'b00, ref_out_gate_on, ref_out_gate_depth}, {2'b00, c != 7, d});
			chk({4'h0, lowlat_polarity_flip}, 8'h0C);
			rd(8'h11, {c[2:0], 5'h0C});
		end
		for (int k = 0; k < 8; k++) begin
			@(posedge mclk);
			high_rate <= k[2];
			wr(8'h12, {6'h07, k[1:0]});
			wr(8'h13, 8'hFF);
			chk({main_out_deemph, ref_out_deemph, ref_out_master_vol_follow, 5'h00}, {~k[2], ~k[2], 6'h20});
			chk({6'h00, ref_out_hold, ref_out_tracking}, {6'h00, k[1:0] == 2'h1, k[1:0] == 2'h2});
			chk({3'h0, out_polarity_flip}, {3'h0, k[1:0] != 2'h2, 4'hF});
		end
		wr(8'h15, 8'h40);
		chk({6'h00, tracking_gain_two, tracking_offset_double}, 8'h03);
		@(posedge mclk);
		tracking_ref_flip <= 1'b0;
		@(posedge mclk);
		#1;
		chk({6'h00, tracking_gain_two, tracking_offset_double}, 8'h00);
		wr(8'h16, 8'hFF);
		rd(8'h16, 8'h00);
		rd(8'h0E, 8'h00);
		rd(8'h15, 8'h40);
		@(posedge mclk);
		#1;
		chk({ctl_rd_valid, ctl_rd_data[6:0]}, 8'h00);
		// Write and read of one address in the same cycle return the old value
		@(posedge mclk);
		ctl_wr_en <= 1'b1;
		ctl_rd_en <= 1'b1;
		ctl_addr <= 8'h10;
		ctl_wr_data <= 8'h33;
		@(posedge mclk);
		ctl_wr_en <= 1'b0;
		ctl_rd_en <= 1'b0;
		#1;
		chk(ctl_rd_data, 8'h5A);
		rd(8'h10, 8'h33);
		wr(8'h15, 8'h80);
		chk({7'h00, common_mode_discharge}, 8'h01);
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		rd(8'h10, 8'h00);
		rd(8'h14, 8'h00);
		rd(8'h15, 8'h00);
		report_and_stop;
	end
endmodule : cpcr_path_ctrl_tb
